// File: inc/fmpc_regs.svh
// Purpose: Offsets, fields, reset values and counts of the field memory pointer control
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes: Definitions only
`ifndef FMPC_REGS_SVH
`define FMPC_REGS_SVH

// Register byte offsets
`define FMPC_CTRL_OFS 5'h00
`define FMPC_RD_JUMP_OFS 5'h04
`define FMPC_WR_JUMP_OFS 5'h08
`define FMPC_RD_PTR_OFS 5'h0c
`define FMPC_WR_PTR_OFS 5'h10
`define FMPC_STATUS_OFS 5'h14

// Field positions
`define FMPC_CTRL_GEOM_BIT 0
`define FMPC_JUMP_DOT_LSB 0
`define FMPC_JUMP_LINE_LSB 16
`define FMPC_PTR_WIN_BIT 31
`define FMPC_ST_RD_SPACING 0
`define FMPC_ST_WR_SPACING 1
`define FMPC_ST_WR_PARTIAL 2
`define FMPC_ST_RD_BADJUMP 3
`define FMPC_ST_WR_BADJUMP 4
`define FMPC_ST_W1C_MASK 32'h0000001f

// Reset values
`define FMPC_CTRL_RST 32'h00000000
`define FMPC_JUMP_RST 32'h00000000

// Geometries: 324 lines x 1024 dots, 288 lines x 1152 dots
`define FMPC_GEOM0_LINES 9'h144
`define FMPC_GEOM0_DOTS 11'h400
`define FMPC_GEOM1_LINES 9'h120
`define FMPC_GEOM1_DOTS 11'h480

// Counts in port clock cycles
`define FMPC_RST_SPACING 8'h40
`define FMPC_PARTIAL_SPACING 8'ha0
`define FMPC_UNIT_WORDS 6'h20
`define FMPC_GAP_MAX 8'hff

`endif

// File: inc/fmpc_pkg.sv
// Purpose: Types shared by the field memory pointer control
// Assumes: Nothing beyond the register header
// Notes: Operation decode of the port strobes lives here
package fmpc_pkg;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    FMPC_BUS_IDLE = 2'b01,
    FMPC_BUS_ACK = 2'b10
  } fmpc_bus_e;

  // Pointer operations taken at a port clock rise
  typedef enum logic [3:0] {
    FMPC_OP_INC = 4'h0,
    FMPC_OP_LINE_INC = 4'h1,
    FMPC_OP_LINE_HOLD = 4'h2,
    FMPC_OP_ADDR_SET = 4'h3,
    FMPC_OP_JUMP = 4'h4,
    FMPC_OP_WIN_JUMP = 4'h5,
    FMPC_OP_RESET = 4'h6,
    FMPC_OP_WIN_RESET = 4'h7,
    FMPC_OP_CLEAR = 4'h8,
    FMPC_OP_NONE = 4'h9
  } fmpc_op_e;

  // Strobes are active low; window select low means window mode
  function automatic fmpc_op_e fmpc_decode(input logic rs_n, input logic as_n,
                                           input logic lrs_n, input logic wnd_n,
                                           input logic clr_n);
    fmpc_op_e op;
    op = FMPC_OP_NONE;
    if (!clr_n) begin
      op = FMPC_OP_CLEAR;
    end else if (!as_n) begin
      if (!lrs_n) op = FMPC_OP_NONE;
      else if (rs_n) op = FMPC_OP_ADDR_SET;
      else if (wnd_n) op = FMPC_OP_JUMP;
      else op = FMPC_OP_WIN_JUMP;
    end else if (!lrs_n) begin
      op = rs_n ? FMPC_OP_LINE_INC : FMPC_OP_LINE_HOLD;
    end else if (!rs_n) begin
      op = wnd_n ? FMPC_OP_RESET : FMPC_OP_WIN_RESET;
    end else begin
      op = FMPC_OP_INC;
    end
    return op;
  endfunction : fmpc_decode

  // Any system reset class operation, address setup included
  function automatic logic fmpc_is_sys(input fmpc_op_e op);
    return (op != FMPC_OP_INC) && (op != FMPC_OP_NONE);
  endfunction : fmpc_is_sys

endpackage : fmpc_pkg

// File: verilog/fmpc_sync.sv
// Purpose: Two-flop synchroniser for the port pins
// Assumes: Pins are asynchronous to clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module fmpc_sync #(
  parameter int W = 14
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // A bank without bits has nothing to carry
  if (W < 1) begin : g_bad_w
    $error("fmpc_sync needs W of at least 1");
  end

  // One synchroniser per pin bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    always_comb begin
      meta_d = din[i];
      sync_d = meta_q;
    end
    always_ff @(posedge clk) begin
      if (!rstn) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= meta_d;
        sync_q <= sync_d;
      end
    end
    assign dout[i] = sync_q;
  end

endmodule : fmpc_sync
`default_nettype wire

// File: verilog/fmpc_top.sv
// Purpose: Read and write address pointer control of a dual-port serial field memory
// Assumes: clk at 40 MHz, faster than both port clocks; pins pass fmpc_sync first
// Notes: Registers over Avalon-MM; answers one cycle after a request
`timescale 1ns/1ps
`default_nettype none
`include "fmpc_regs.svh"

//Contract
// - Truncating write reset commits words written so far only.
// - Short write commits its last address only on a following reset.
// - Gated read: first reset held, run at first clock after gate low.
// - Gated write: one reset held, run at first clock after gate low.
// - Spacing violation corrupts data only; pointers stay correct.
// - Window jump goes to the window's first point.
// - Window line increment goes to left edge, next line.
// - Window line hold goes to left edge, same line.
// - Window reset goes to the window origin.
// - Read and write scan independent windows.
// - Geometries 324x1024 and 288x1152 are supported.
// - Pointer advances each port clock, stops at line end.
module fmpc_top
  import fmpc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] address,
  input wire logic [3:0] byteenable,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic read_port_clock,
  input wire logic read_clock_gate,
  input wire logic read_reset_strobe_n,
  input wire logic read_addr_set_n,
  input wire logic read_line_strobe_n,
  input wire logic read_window_select_n,
  input wire logic read_clear_n,
  input wire logic write_port_clock,
  input wire logic write_clock_gate,
  input wire logic write_reset_strobe_n,
  input wire logic write_addr_set_n,
  input wire logic write_line_strobe_n,
  input wire logic write_window_select_n,
  input wire logic write_clear_n,
  output logic [8:0] read_line,
  output logic [10:0] read_dot,
  output logic read_window_on,
  output logic [8:0] write_line,
  output logic [10:0] write_dot,
  output logic write_window_on,
  output logic write_commit,
  output logic [5:0] write_commit_count,
  output logic [8:0] write_commit_line,
  output logic [10:0] write_commit_dot
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Pins into the clk domain; port 0 is read, port 1 is write
  logic [13:0] pin_s;
  fmpc_sync #(.W(14)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({write_clear_n, write_window_select_n, write_line_strobe_n, write_addr_set_n,
          write_reset_strobe_n, write_clock_gate, write_port_clock,
          read_clear_n, read_window_select_n, read_line_strobe_n, read_addr_set_n,
          read_reset_strobe_n, read_clock_gate, read_port_clock}),
    .dout(pin_s)
  );

  // Register file state
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] jump_q [2];
  logic [31:0] jump_d [2];
  logic [31:0] status_q, status_d;
  fmpc_bus_e bus_q, bus_d;
  logic [31:0] rdata_q, rdata_d;

  // Geometry, shared by both ports
  logic [8:0] last_line;
  logic [10:0] last_dot;
  always_comb begin
    if (ctrl_q[`FMPC_CTRL_GEOM_BIT]) begin
      last_line = `FMPC_GEOM1_LINES - 9'h1;
      last_dot = `FMPC_GEOM1_DOTS - 11'h1;
    end else begin
      last_line = `FMPC_GEOM0_LINES - 9'h1;
      last_dot = `FMPC_GEOM0_DOTS - 11'h1;
    end
  end

  // Per-port views for the generate loop
  logic [8:0] line_q [2];
  logic [10:0] dot_q [2];
  logic win_q [2];
  logic [7:0] gap_q [2];
  logic exec [2];
  fmpc_op_e op_x [2];
  logic viol_sp [2];
  logic viol_bj [2];

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic clk_s, gate_s, prev_q, prev_d, edge_s;
    fmpc_op_e op_in;
    logic [8:0] line_d, org_line_q, org_line_d, set_line_q, set_line_d;
    logic [10:0] dot_d, org_dot_q, org_dot_d, set_dot_q, set_dot_d;
    logic win_d, pend_q, pend_d;
    fmpc_op_e pend_op_q, pend_op_d;
    logic [7:0] gap_d;
    logic [8:0] jl;
    logic [10:0] jd;

    assign clk_s = pin_s[7*p];
    assign gate_s = pin_s[7*p+1];
    assign edge_s = clk_s & ~prev_q;
    assign op_in = fmpc_decode(pin_s[7*p+2], pin_s[7*p+3], pin_s[7*p+4],
                               pin_s[7*p+5], pin_s[7*p+6]);
    assign jl = jump_q[p][`FMPC_JUMP_LINE_LSB +: 9];
    assign jd = jump_q[p][`FMPC_JUMP_DOT_LSB +: 11];
    assign exec[p] = edge_s & ~gate_s;
    assign op_x[p] = pend_q ? pend_op_q : op_in;

    // Pointer, window and hold-off next state
    always_comb begin
      prev_d = clk_s;
      line_d = line_q[p];
      dot_d = dot_q[p];
      org_line_d = org_line_q;
      org_dot_d = org_dot_q;
      set_line_d = set_line_q;
      set_dot_d = set_dot_q;
      win_d = win_q[p];
      pend_d = pend_q;
      pend_op_d = pend_op_q;
      gap_d = (gap_q[p] == `FMPC_GAP_MAX) ? gap_q[p] : gap_q[p] + 8'h1;
      viol_sp[p] = 1'b0;
      viol_bj[p] = 1'b0;
      if (!edge_s) begin
        gap_d = gap_q[p];
      end else if (gate_s) begin
        gap_d = gap_q[p];
        if (!pend_q && fmpc_is_sys(op_in) && op_in != FMPC_OP_ADDR_SET) begin
          pend_d = 1'b1;
          pend_op_d = op_in;
        end
      end else begin
        pend_d = 1'b0;
        if (fmpc_is_sys(op_x[p])) begin
          gap_d = 8'h1;
          viol_sp[p] = gap_q[p] < `FMPC_RST_SPACING;
        end
        case (op_x[p])
          FMPC_OP_INC: begin
            if (dot_q[p] != last_dot) dot_d = dot_q[p] + 11'h1;
          end
          FMPC_OP_LINE_INC: begin
            if (line_q[p] != last_line) line_d = line_q[p] + 9'h1;
            dot_d = win_q[p] ? org_dot_q : 11'h0;
          end
          FMPC_OP_LINE_HOLD: begin
            dot_d = win_q[p] ? org_dot_q : 11'h0;
          end
          FMPC_OP_ADDR_SET: begin
            set_line_d = jl;
            set_dot_d = jd;
            // zero, line end and lines past the last flagged as targets, still loaded
            viol_bj[p] = (jl == 9'h0 && jd == 11'h0) || jd >= last_dot || jl > last_line;
          end
          FMPC_OP_JUMP: begin
            line_d = set_line_q;
            dot_d = set_dot_q;
            win_d = 1'b0;
          end
          FMPC_OP_WIN_JUMP: begin
            line_d = set_line_q;
            dot_d = set_dot_q;
            org_line_d = set_line_q;
            org_dot_d = set_dot_q;
            win_d = 1'b1;
            viol_bj[p] = (p == 0) && (set_dot_q != 11'h0);
          end
          FMPC_OP_WIN_RESET: begin
            line_d = org_line_q;
            dot_d = org_dot_q;
          end
          FMPC_OP_RESET, FMPC_OP_CLEAR: begin
            line_d = 9'h0;
            dot_d = 11'h0;
            win_d = 1'b0;
          end
          default: begin
            line_d = line_q[p];
          end
        endcase
      end
    end

    // Register the port state
    always_ff @(posedge clk) begin
      if (!rstn) begin
        prev_q <= 1'b0;
        line_q[p] <= 9'h0;
        dot_q[p] <= 11'h0;
        org_line_q <= 9'h0;
        org_dot_q <= 11'h0;
        set_line_q <= 9'h0;
        set_dot_q <= 11'h0;
        win_q[p] <= 1'b0;
        pend_q <= 1'b0;
        pend_op_q <= FMPC_OP_NONE;
        gap_q[p] <= `FMPC_GAP_MAX;
      end else begin
        prev_q <= prev_d;
        line_q[p] <= line_d;
        dot_q[p] <= dot_d;
        org_line_q <= org_line_d;
        org_dot_q <= org_dot_d;
        set_line_q <= set_line_d;
        set_dot_q <= set_dot_d;
        win_q[p] <= win_d;
        pend_q <= pend_d;
        pend_op_q <= pend_op_d;
        gap_q[p] <= gap_d;
      end
    end

    inc_stop_a: assert property (exec[p] && op_x[p] == FMPC_OP_INC
      |=> dot_q[p] == (($past(dot_q[p]) == last_dot) ? last_dot : $past(dot_q[p]) + 11'h1))
      else $error("pointer increment wrong");
    gate_hold_a: assert property (edge_s && gate_s
      |=> $stable(dot_q[p]) && $stable(line_q[p]))
      else $error("pointer moved while gated");
    gate_exec_a: assert property (pend_q && exec[p] |=> !pend_q && !$stable(gap_q[p]))
      else $error("held reset not executed");
    win_jump_a: assert property (exec[p] && op_x[p] == FMPC_OP_WIN_JUMP
      |=> win_q[p] && line_q[p] == org_line_q && dot_q[p] == org_dot_q)
      else $error("window jump target wrong");
    line_inc_a: assert property (exec[p] && op_x[p] == FMPC_OP_LINE_INC && win_q[p]
      |=> dot_q[p] == org_dot_q)
      else $error("window line increment wrong");
    win_reset_a: assert property (exec[p] && op_x[p] == FMPC_OP_WIN_RESET
      |=> line_q[p] == org_line_q && dot_q[p] == org_dot_q)
      else $error("window reset wrong");
    cov_win_jump: cover property (exec[p] && op_x[p] == FMPC_OP_WIN_JUMP);
    cov_gated: cover property (pend_q && exec[p]);
  end

  logic [5:0] cnt_q, cnt_d;
  logic [8:0] base_line_q, base_line_d;
  logic [10:0] base_dot_q, base_dot_d;
  logic [7:0] pgap_q, pgap_d;
  logic cm_q, cm_d, viol_part;
  logic [5:0] cm_cnt_q, cm_cnt_d;
  logic [8:0] cm_line_q, cm_line_d;
  logic [10:0] cm_dot_q, cm_dot_d;
  always_comb begin
    cnt_d = cnt_q;
    base_line_d = base_line_q;
    base_dot_d = base_dot_q;
    pgap_d = pgap_q;
    cm_d = 1'b0;
    cm_cnt_d = cm_cnt_q;
    cm_line_d = cm_line_q;
    cm_dot_d = cm_dot_q;
    viol_part = 1'b0;
    if (exec[1]) begin
      if (pgap_q != `FMPC_GAP_MAX) pgap_d = pgap_q + 8'h1;
      if (op_x[1] == FMPC_OP_INC) begin
        if (cnt_q == 6'h0) begin
          base_line_d = line_q[1];
          base_dot_d = dot_q[1];
        end
        cnt_d = cnt_q + 6'h1;
        if (cnt_d == `FMPC_UNIT_WORDS) begin
          cm_d = 1'b1;
          cm_cnt_d = cnt_d;
          cm_line_d = (cnt_q == 6'h0) ? line_q[1] : base_line_q;
          cm_dot_d = (cnt_q == 6'h0) ? dot_q[1] : base_dot_q;
          cnt_d = 6'h0;
        end
      end else if (fmpc_is_sys(op_x[1]) && op_x[1] != FMPC_OP_ADDR_SET && cnt_q != 6'h0) begin
        cm_d = 1'b1;
        cm_cnt_d = cnt_q;
        cm_line_d = base_line_q;
        cm_dot_d = base_dot_q;
        cnt_d = 6'h0;
        viol_part = pgap_q < `FMPC_PARTIAL_SPACING;
        pgap_d = 8'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 6'h0;
      base_line_q <= 9'h0;
      base_dot_q <= 11'h0;
      pgap_q <= `FMPC_GAP_MAX;
      cm_q <= 1'b0;
      cm_cnt_q <= 6'h0;
      cm_line_q <= 9'h0;
      cm_dot_q <= 11'h0;
    end else begin
      cnt_q <= cnt_d;
      base_line_q <= base_line_d;
      base_dot_q <= base_dot_d;
      pgap_q <= pgap_d;
      cm_q <= cm_d;
      cm_cnt_q <= cm_cnt_d;
      cm_line_q <= cm_line_d;
      cm_dot_q <= cm_dot_d;
    end
  end

  partial_commit_a: assert property (exec[1] && fmpc_is_sys(op_x[1])
    && op_x[1] != FMPC_OP_ADDR_SET && cnt_q != 6'h0
    |=> cm_q && cm_cnt_q == $past(cnt_q) && cnt_q == 6'h0)
    else $error("short unit not committed");
  cov_partial: cover property (cm_q && cm_cnt_q != `FMPC_UNIT_WORDS);

  // Byte-lane merge of a register write
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : be_merge

  // Bus slave: sample read data, then answer on the next cycle
  logic wr_go;
  logic [31:0] sets;
  assign wr_go = (bus_q == FMPC_BUS_ACK) && write;
  assign waitrequest = (read || write) && (bus_q == FMPC_BUS_IDLE);
  always_comb begin
    bus_d = bus_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    jump_d = jump_q;
    sets = 32'h0;
    sets[`FMPC_ST_RD_SPACING] = viol_sp[0];
    sets[`FMPC_ST_WR_SPACING] = viol_sp[1];
    sets[`FMPC_ST_WR_PARTIAL] = viol_part;
    sets[`FMPC_ST_RD_BADJUMP] = viol_bj[0];
    sets[`FMPC_ST_WR_BADJUMP] = viol_bj[1];
    status_d = status_q | sets;
    case (bus_q)
      FMPC_BUS_IDLE: begin
        if (read || write) begin
          bus_d = FMPC_BUS_ACK;
          case (address)
            `FMPC_CTRL_OFS: rdata_d = ctrl_q;
            `FMPC_RD_JUMP_OFS: rdata_d = jump_q[0];
            `FMPC_WR_JUMP_OFS: rdata_d = jump_q[1];
            `FMPC_RD_PTR_OFS: rdata_d = {win_q[0], 6'h0, line_q[0], 5'h0, dot_q[0]};
            `FMPC_WR_PTR_OFS: rdata_d = {win_q[1], 6'h0, line_q[1], 5'h0, dot_q[1]};
            `FMPC_STATUS_OFS: rdata_d = status_q;
            default: rdata_d = 32'h0;
          endcase
        end
      end
      FMPC_BUS_ACK: begin
        bus_d = FMPC_BUS_IDLE;
        if (wr_go) begin
          case (address)
            `FMPC_CTRL_OFS: ctrl_d = be_merge(ctrl_q, writedata, byteenable) & 32'h1;
            `FMPC_RD_JUMP_OFS: jump_d[0] = be_merge(jump_q[0], writedata, byteenable)
                                           & 32'h01ff07ff;
            `FMPC_WR_JUMP_OFS: jump_d[1] = be_merge(jump_q[1], writedata, byteenable)
                                           & 32'h01ff07ff;
            `FMPC_STATUS_OFS: status_d = (status_q & ~(be_merge(32'h0, writedata,
                                          byteenable) & `FMPC_ST_W1C_MASK)) | sets;
            default: ctrl_d = ctrl_q;
          endcase
        end
      end
      default: bus_d = FMPC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_q <= FMPC_BUS_IDLE;
      rdata_q <= 32'h0;
      ctrl_q <= `FMPC_CTRL_RST;
      jump_q[0] <= `FMPC_JUMP_RST;
      jump_q[1] <= `FMPC_JUMP_RST;
      status_q <= 32'h0;
    end else begin
      bus_q <= bus_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      jump_q <= jump_d;
      status_q <= status_d;
    end
  end

  // Outputs straight from flops
  assign readdata = rdata_q;
  assign read_line = line_q[0];
  assign read_dot = dot_q[0];
  assign read_window_on = win_q[0];
  assign write_line = line_q[1];
  assign write_dot = dot_q[1];
  assign write_window_on = win_q[1];
  assign write_commit = cm_q;
  assign write_commit_count = cm_cnt_q;
  assign write_commit_line = cm_line_q;
  assign write_commit_dot = cm_dot_q;

  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  unmapped_a: assert property (read && !waitrequest && address > `FMPC_STATUS_OFS
    |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  spacing_flag_a: assert property (viol_sp[1] |=> status_q[`FMPC_ST_WR_SPACING])
    else $error("write spacing flag missing");
  cov_bus_write: cover property (write && !waitrequest);

endmodule : fmpc_top
`default_nettype wire

// File: bench/fmpc_ctrl_model.sv
// Purpose: Video controller model driving one pointer port
// Assumes: The bench calls rise once for each port clock it wants
// Notes: Port clock stands low between rises
`timescale 1ns/1ps
`default_nettype none
module fmpc_ctrl_model (
  input wire logic clk,
  output logic port_clock,
  output logic gate,
  output logic rs_n,
  output logic as_n,
  output logic lrs_n,
  output logic wnd_n,
  output logic clr_n
);
  // Idle pins: clock low, strobes inactive
  initial begin
    port_clock = 1'b0;
    gate = 1'b0;
    {rs_n, as_n, lrs_n, wnd_n, clr_n} = 5'h1f;
  end
  // Strobes lead the rise by 3 clk and trail it by 4, so the sync flops see them settled
  task automatic rise(input logic [3:0] s, input logic w, input logic g);
    @(posedge clk);
    gate <= g;
    {rs_n, as_n, lrs_n, clr_n} <= s;
    wnd_n <= w ? s[3] : 1'b1;
    repeat (3) @(posedge clk);
    port_clock <= 1'b1;
    repeat (4) @(posedge clk);
    port_clock <= 1'b0;
    {rs_n, as_n, lrs_n, wnd_n, clr_n} <= 5'h1f;
    repeat (4) @(posedge clk);
  endtask : rise
endmodule : fmpc_ctrl_model
`default_nettype wire

// File: bench/fmpc_top_tb.sv
// Purpose: Self-checking bench of the pointer control
// Assumes: Pointers and status are read back over the bus
// Notes: Spacing is broken on purpose; only status may show it
`timescale 1ns/1ps
`default_nettype none
`include "fmpc_regs.svh"
module fmpc_top_tb;
  localparam logic [4:0] wp = `FMPC_WR_PTR_OFS;
  localparam logic [4:0] rp = `FMPC_RD_PTR_OFS;
  localparam logic [4:0] st = `FMPC_STATUS_OFS;
  logic clk, rstn, read, write, waitrequest, wcommit;
  logic [4:0] address;
  logic [31:0] writedata, readdata;
  logic [5:0] ccount;
  logic rpc, rcg, read_reset_strobe, ras, rls, rwn, rcl, wpc, wcg, write_reset_strobe, was, wls, wwn, wcl;
  logic [31:0] rdq[$];
  logic [5:0] cmq[$];
  int miscompares, checks_done, pend;
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  fmpc_top u_fmpc_top (.clk(clk), .rstn(rstn), .address(address), .byteenable(4'hf),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .read_port_clock(rpc), .read_clock_gate(rcg),
    .read_reset_strobe_n(read_reset_strobe), .read_addr_set_n(ras), .read_line_strobe_n(rls),
    .read_window_select_n(rwn), .read_clear_n(rcl), .write_port_clock(wpc),
    .write_clock_gate(wcg), .write_reset_strobe_n(write_reset_strobe), .write_addr_set_n(was),
    .write_line_strobe_n(wls), .write_window_select_n(wwn), .write_clear_n(wcl),
    .read_line(), .read_dot(), .read_window_on(), .write_line(), .write_dot(),
    .write_window_on(), .write_commit(wcommit), .write_commit_count(ccount),
    .write_commit_line(), .write_commit_dot());
  fmpc_ctrl_model u_rd (.clk(clk), .port_clock(rpc), .gate(rcg), .rs_n(read_reset_strobe),
    .as_n(ras), .lrs_n(rls), .wnd_n(rwn), .clr_n(rcl));
  fmpc_ctrl_model u_wr (.clk(clk), .port_clock(wpc), .gate(wcg), .rs_n(write_reset_strobe),
    .as_n(was), .lrs_n(wls), .wnd_n(wwn), .clr_n(wcl));
  task automatic chk_bus(input logic [31:0] exp);
    checks_done++;
    if (readdata !== exp) begin
      miscompares++;
      $display("Error readdata expected %h seen %h", exp, readdata);
    end
  endtask : chk_bus
  task automatic chk_commit(input logic [5:0] exp);
    checks_done++;
    if (ccount !== exp) begin
      miscompares++;
      $display("Error commit count expected %h seen %h", exp, ccount);
    end
  endtask : chk_commit
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Read data are taken at the edge that sees waitrequest low; a commit pulse lasts one cycle
  always @(posedge clk) begin
    if (read && !waitrequest) chk_bus(rdq.pop_front());
    if (wcommit === 1'b1) chk_commit(cmq.size() ? cmq.pop_front() : 6'h3f);
  end
  // For a read, d is the expected value, noted before the request goes out
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (!w) rdq.push_back(d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      results();
    end
  endtask : bus
  // Write op that also notes the commit it should cause
  task automatic wop(input logic [3:0] s, input logic w, input logic g);
    if (s == 4'hf && !g) pend++;
    if (pend == 32 || (s != 4'hf && s != 4'hb && pend > 0)) begin
      cmq.push_back(6'(pend));
      pend = 0;
    end
    u_wr.rise(s, w, g);
  endtask : wop
  function automatic logic [31:0] pw(input logic w, input logic [8:0] l, input logic [10:0] d);
    return {w, 6'h00, l, 5'h00, d};
  endfunction : pw
  // Watchdog cuts a hang short
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    int n;
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    void'($urandom(32'h7f0a));
    bus(0, `FMPC_CTRL_OFS, `FMPC_CTRL_RST);
    bus(0, `FMPC_RD_JUMP_OFS, `FMPC_JUMP_RST);
    bus(1, 5'h18, 32'hffff_ffff);
    bus(0, 5'h18, 32'h0);
    bus(0, wp, 32'h0);
    $display("test 1 done");
    bus(1, `FMPC_WR_JUMP_OFS, 32'h0005_0007);
    wop(4'hb, 0, 0);
    // jump must come 64 port clocks after the set; broken here, flagged only
    wop(4'h3, 0, 0);
    n = $urandom_range(31, 1);
    repeat (n) wop(4'hf, 0, 0);
    bus(0, wp, pw(0, 9'h005, 11'(7 + n)));
    wop(4'h7, 0, 0);
    repeat (32) wop(4'hf, 0, 0);
    wop(4'hd, 0, 0);
    bus(0, wp, pw(0, 9'h001, 11'h000));
    $display("test 2 done");
    bus(1, `FMPC_WR_JUMP_OFS, 32'h000a_0014);
    wop(4'hb, 0, 0);
    // no window is open before this window jump
    wop(4'h3, 1, 0);
    bus(0, wp, pw(1, 9'h00a, 11'h014));
    repeat (2) wop(4'hf, 1, 0);
    wop(4'hd, 1, 0);
    bus(0, wp, pw(1, 9'h00b, 11'h014));
    wop(4'hf, 1, 0);
    wop(4'h5, 1, 0);
    bus(0, wp, pw(1, 9'h00b, 11'h014));
    wop(4'h7, 1, 0);
    bus(0, wp, pw(1, 9'h00a, 11'h014));
    wop(4'he, 0, 0);
    bus(0, wp, 32'h0);
    $display("test 3 done");
    bus(1, `FMPC_CTRL_OFS, 32'h1);
    bus(1, `FMPC_RD_JUMP_OFS, 32'h0003_047e);
    u_rd.rise(4'hb, 0, 0);
    // read jump right after its set, flagged only
    u_rd.rise(4'h3, 0, 0);
    repeat (3) u_rd.rise(4'hf, 0, 0);
    bus(0, rp, pw(0, 9'h003, 11'h47f));
    bus(0, wp, 32'h0);
    u_rd.rise(4'h7, 0, 1);
    u_rd.rise(4'h3, 0, 1);
    bus(0, rp, pw(0, 9'h003, 11'h47f));
    u_rd.rise(4'hf, 0, 0);
    bus(0, rp, 32'h0);
    bus(1, `FMPC_RD_JUMP_OFS, 32'h0002_0000);
    u_rd.rise(4'hb, 0, 0);
    u_rd.rise(4'h3, 1, 0);
    u_rd.rise(4'hd, 1, 0);
    bus(0, rp, pw(1, 9'h003, 11'h000));
    $display("test 4 done");
    repeat (3) wop(4'hf, 0, 0);
    wop(4'h7, 0, 1);
    bus(0, wp, pw(0, 9'h000, 11'h003));
    u_wr.rise(4'hf, 0, 0);
    bus(0, wp, 32'h0);
    $display("test 5 done");
    // Short write resets came closer than 160 write clocks apart
    bus(0, st, 32'h7);
    bus(1, st, `FMPC_ST_W1C_MASK);
    bus(0, st, 32'h0);
    u_rd.rise(4'h7, 0, 0);
    u_rd.rise(4'h7, 0, 0);
    bus(0, st, 32'h1);
    bus(1, st, 32'h1);
    bus(1, `FMPC_RD_JUMP_OFS, 32'h0);
    u_rd.rise(4'hb, 0, 0);
    bus(0, st, 32'h9);
    $display("test 6 done");
    if (cmq.size() != 0) miscompares++;
    results();
  end
endmodule : fmpc_top_tb
`default_nettype wire
